// file: hdl/program_space_params.svh
// Constants for the program space identity and map block:
// register offsets, field positions, reset values and vectors.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef PROGRAM_SPACE_PARAMS_SVH
`define PROGRAM_SPACE_PARAMS_SVH

// Printed word indices of the identity and configuration words
`define IDX_REVISION 16'h8005
`define IDX_PART 16'h8006
`define IDX_PROT_CFG 16'h800b

// Own control registers, byte addresses
`define ADDR_CTRL 18'h00000
`define ADDR_PROG_ADDR 18'h00004
`define ADDR_PROG_DATA 18'h00008
`define ADDR_STATUS 18'h0000c

// Field positions
`define CTRL_RUN 0
`define CTRL_IRQ_EN 1
`define CTRL_ERASE 2
`define CTRL_RESTART 3
`define LOCK_BIT 0
`define STAT_LOCKED 0
`define STAT_ERASING 1

// Reserved bit values and reset values
`define PART_RSVD 2'b11
`define REV_RSVD 2'b10
`define PROT_CFG_RSVD 13'h1fff
`define ERASED_WORD 14'h3fff
`define RESET_VECTOR 15'h0000
`define IRQ_VECTOR 15'h0004

`endif

// file: hdl/program_space_pkg.sv
// Types shared by the program space identity and map block.
// Assumes the params header is included by users of the offsets.
package program_space_pkg;

  typedef enum logic [1:0] {
    erase_idle_type_s = 2'b00,
    erase_walk_type_s = 2'b01,
    erase_done_type_s = 2'b10
  } erase_state_type;

  typedef logic [13:0] prog_word_type;
  typedef logic [14:0] prog_addr_type;

endpackage : program_space_pkg

// file: hdl/pc_sequencer.sv
// Program counter with reset and interrupt vectors and wrap-around.
// Assumes step, take_irq and restart come from logic on pclk.
`timescale 1ns/1ns
`include "program_space_params.svh"
module pc_sequencer
  import program_space_pkg::*;
#(
  parameter int PC_W = 15,
  parameter logic [14:0] ADDR_MASK = 15'h07ff
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic step, // Advance to next word
  input wire logic take_irq, // Jump to interrupt vector
  input wire logic restart, // Jump to reset vector
  output logic [PC_W-1:0] pc // Current fetch address
);

  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] pc_inc;

  // Wrap into implemented space
  assign pc_inc = (pc_r + 1'b1) & ADDR_MASK[PC_W-1:0]; // R09
  assign pc_nxt = restart ? `RESET_VECTOR : // R11
                  take_irq ? `IRQ_VECTOR : // R11
                  step ? pc_inc : pc_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= `RESET_VECTOR; // R11
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign pc = pc_r;

endmodule : pc_sequencer

// file: hdl/program_store.sv
// Program word array with a fetch read port, a data read port and
// one write port. Addresses wrap into the implemented depth.
// Assumes all ports are driven from logic on pclk.
`timescale 1ns/1ns
module program_store
  import program_space_pkg::*;
#(
  parameter int DEPTH = 2048,
  parameter int ADDR_W = 15,
  parameter int DATA_W = 14
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [ADDR_W-1:0] fetch_addr, // Instruction fetch address
  output logic [DATA_W-1:0] fetch_word, // Fetched word, next cycle
  input wire logic [ADDR_W-1:0] data_addr, // Data-side read address
  output logic [DATA_W-1:0] data_word, // Data-side word, next cycle
  input wire logic wr_en, // Write strobe
  input wire logic [ADDR_W-1:0] wr_addr, // Write address
  input wire logic [DATA_W-1:0] wr_data // Write word
);

  localparam int IW = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [IW-1:0] fetch_idx;
  logic [IW-1:0] data_idx;
  logic [IW-1:0] wr_idx;

  // High address bits dropped: wrap-around
  assign fetch_idx = fetch_addr[IW-1:0]; // R09
  assign data_idx = data_addr[IW-1:0]; // R09
  assign wr_idx = wr_addr[IW-1:0];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Two independent read ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_word <= '0;
      data_word <= '0;
    end else begin
      fetch_word <= mem[fetch_idx]; // R12
      data_word <= mem[data_idx]; // R12
    end
  end

endmodule : program_store

// file: hdl/program_space_id_map.sv
// Identity words, code lock and program address map, behind APB.
// Assumes an APB3 master on pclk and an asynchronous irq pin.
//
// What this block does
// R01: Part identity word bits 13 and 12 always read as one.
// R02: Part identity word bits 11:0 hold a fixed read-only part code.
// R03: Revision word bit 13 reads one, bit 12 reads zero.
// R04: Revision word bits 11:6 hold the read-only major step number.
// R05: Revision word bits 5:0 hold the read-only minor step number.
// R06: Lock acts at once, so the programmer writes it last.
// R07: Once locked, only a bulk erase removes the code lock. Here presetn also clears lock_r.
// R08: Program counter is 15 bits, addressing up to 32K 14-bit words.
// R09: Accesses above implemented memory wrap into the implemented space.
// R10: Implemented memory is 2048 words or 4096 words per variant.
// R11: Execution starts at 0000h after reset; interrupts enter at 0004h.
// R12: Instruction fetch and data access use separate buses, same cycle.
// R13: Writes to identity and revision words are ignored.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "program_space_params.svh"
module program_space_id_map
  import program_space_pkg::*;
#(
  parameter int MEM_WORDS = 2048, // 2048 or 4096
  parameter logic [11:0] PART_CODE = 12'h5a1, // Arbitrary value
  parameter logic [5:0] MAJOR_STEP = 6'h01, // Arbitrary value
  parameter logic [5:0] MINOR_STEP = 6'h02 // Arbitrary value
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [17:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic irq_pin, // Asynchronous interrupt request
  output logic [14:0] fetch_addr, // Current program counter
  output logic [13:0] fetch_word, // Word fetched at last address
  output logic code_locked, // Code lock active
  output logic erase_busy // Bulk erase in progress
);

  // ----------------------------------------------------------------
  // Variant size and wrap mask
  // ----------------------------------------------------------------
  localparam int IW = $clog2(MEM_WORDS);
  localparam logic [14:0] ADDR_MASK = 15'(MEM_WORDS - 1); // R10
  localparam logic [17:0] ADDR_REVISION = {`IDX_REVISION, 2'b00};
  localparam logic [17:0] ADDR_PART = {`IDX_PART, 2'b00};
  localparam logic [17:0] ADDR_PROT_CFG = {`IDX_PROT_CFG, 2'b00};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic run_r;
  logic irq_en_r;
  logic [14:0] prog_addr_r;
  logic lock_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_meta_r;
  logic irq_sync_r;
  logic irq_prev_r;
  erase_state_type erase_state_r;
  erase_state_type erase_state_nxt;
  logic [IW-1:0] erase_cnt_r;
  logic [IW-1:0] erase_cnt_nxt;
  logic step_r;

  // ----------------------------------------------------------------
  // Identity words
  // ----------------------------------------------------------------
  wire [13:0] part_identity_word;
  wire [13:0] silicon_revision_word;
  wire [13:0] protection_config_word;
  wire [11:0] part_code_field;
  wire [5:0] major_step_field;
  wire [5:0] minor_step_field;
  wire code_lock_bit;

  assign part_code_field = PART_CODE; // R02
  assign major_step_field = MAJOR_STEP; // R04
  assign minor_step_field = MINOR_STEP; // R05
  assign part_identity_word = {`PART_RSVD, part_code_field}; // R01
  assign silicon_revision_word = {`REV_RSVD, major_step_field, minor_step_field}; // R03
  // Lock is active low in the configuration word
  assign code_lock_bit = ~lock_r;
  assign protection_config_word = {`PROT_CFG_RSVD, code_lock_bit};

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_acc;
  wire done_acc;
  wire wr_done;
  wire sel_ctrl;
  wire sel_prog_addr;
  wire sel_prog_data;
  wire sel_status;
  wire sel_revision;
  wire sel_part;
  wire sel_prot_cfg;
  wire mapped;

  assign setup_acc = psel & penable & ~pready_r;
  assign done_acc = psel & penable & pready_r;
  assign wr_done = done_acc & pwrite;
  assign sel_ctrl = paddr == `ADDR_CTRL;
  assign sel_prog_addr = paddr == `ADDR_PROG_ADDR;
  assign sel_prog_data = paddr == `ADDR_PROG_DATA;
  assign sel_status = paddr == `ADDR_STATUS;
  assign sel_revision = paddr == ADDR_REVISION;
  assign sel_part = paddr == ADDR_PART;
  assign sel_prot_cfg = paddr == ADDR_PROT_CFG;
  assign mapped = sel_ctrl | sel_prog_addr | sel_prog_data | sel_status |
                  sel_revision | sel_part | sel_prot_cfg; // R13

  // ----------------------------------------------------------------
  // Write effects
  // ----------------------------------------------------------------
  wire erase_busy_w;
  wire ctrl_wr;
  wire prog_addr_wr;
  wire prog_data_wr;
  wire prot_cfg_wr;
  wire erase_start;
  wire restart_req;

  assign ctrl_wr = wr_done & sel_ctrl;
  assign prog_addr_wr = wr_done & sel_prog_addr;
  // Programming blocked while locked or erasing
  assign prog_data_wr = wr_done & sel_prog_data & ~lock_r & ~erase_busy_w; // R07
  assign prot_cfg_wr = wr_done & sel_prot_cfg & ~erase_busy_w;
  assign erase_start = ctrl_wr & pwdata[`CTRL_ERASE] & ~erase_busy_w;
  assign restart_req = ctrl_wr & pwdata[`CTRL_RESTART];
  // Identity word writes have no target, so they are ignored

  // ----------------------------------------------------------------
  // Bulk erase walk
  // ----------------------------------------------------------------
  wire erase_last;
  wire erase_wr;

  assign erase_busy_w = erase_state_r != erase_idle_type_s;
  assign erase_last = erase_cnt_r == IW'(MEM_WORDS - 1);
  assign erase_wr = erase_state_r == erase_walk_type_s;

  always_comb begin
    erase_state_nxt = erase_state_r;
    erase_cnt_nxt = erase_cnt_r;
    unique case (erase_state_r)
      erase_idle_type_s: begin
        if (erase_start) begin
          erase_state_nxt = erase_walk_type_s;
          erase_cnt_nxt = '0;
        end
      end
      erase_walk_type_s: begin
        erase_cnt_nxt = erase_cnt_r + 1'b1;
        if (erase_last) begin
          erase_state_nxt = erase_done_type_s;
        end
      end
      erase_done_type_s: begin
        erase_state_nxt = erase_idle_type_s;
      end
      default: begin
        erase_state_nxt = erase_idle_type_s;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_state_r <= erase_idle_type_s;
      erase_cnt_r <= '0;
    end else begin
      erase_state_r <= erase_state_nxt;
      erase_cnt_r <= erase_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Code lock
  // ----------------------------------------------------------------
  wire lock_nxt;

  // Config write can only set the lock; only erase end or reset clears it
  assign lock_nxt = (erase_state_r == erase_done_type_s) ? 1'b0 : // R07
                    (prot_cfg_wr & ~pwdata[`LOCK_BIT]) ? 1'b1 : lock_r; // R06

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt; // R07
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      irq_en_r <= 1'b0;
    end else if (ctrl_wr) begin
      run_r <= pwdata[`CTRL_RUN];
      irq_en_r <= pwdata[`CTRL_IRQ_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_addr_r <= '0;
    end else if (prog_addr_wr) begin
      prog_addr_r <= pwdata[14:0]; // R08
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin synchroniser and edge detect
  // ----------------------------------------------------------------
  wire irq_take;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
      irq_prev_r <= 1'b0;
    end else begin
      irq_meta_r <= irq_pin;
      irq_sync_r <= irq_meta_r;
      irq_prev_r <= irq_sync_r;
    end
  end

  assign irq_take = irq_sync_r & ~irq_prev_r & irq_en_r & run_r & ~erase_busy_w;

  // ----------------------------------------------------------------
  // Program counter and store
  // ----------------------------------------------------------------
  wire [14:0] pc_w;
  wire [13:0] data_word_w;
  wire store_wr;
  wire [14:0] store_wr_addr;
  wire [13:0] store_wr_data;
  wire run_step;

  assign run_step = run_r & ~erase_busy_w;
  assign store_wr = prog_data_wr | erase_wr;
  assign store_wr_addr = erase_wr ? 15'(erase_cnt_r) : prog_addr_r;
  assign store_wr_data = erase_wr ? `ERASED_WORD : pwdata[13:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= 1'b0;
    end else begin
      step_r <= run_step;
    end
  end

  pc_sequencer #(
    .PC_W(15),
    .ADDR_MASK(ADDR_MASK)
  ) u_pc (
    .pclk(pclk),
    .presetn(presetn),
    .step(step_r),
    .take_irq(irq_take), // R11
    .restart(restart_req), // R11
    .pc(pc_w) // R08
  );

  program_store #(
    .DEPTH(MEM_WORDS),
    .ADDR_W(15),
    .DATA_W(14)
  ) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .fetch_addr(pc_w), // R12
    .fetch_word(fetch_word),
    .data_addr(prog_addr_r), // R12
    .data_word(data_word_w),
    .wr_en(store_wr),
    .wr_addr(store_wr_addr),
    .wr_data(store_wr_data)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] ctrl_rd;
  wire [31:0] status_rd;
  wire [31:0] prog_data_rd;
  wire [31:0] rd_mux;

  assign ctrl_rd = {28'h0000000, 1'b0, erase_busy_w, irq_en_r, run_r};
  assign status_rd = {1'b0, pc_w, 14'h0000, erase_busy_w, lock_r};
  // Locked program words read as zero on the data side
  assign prog_data_rd = lock_r ? 32'h00000000 : {18'h00000, data_word_w}; // R07
  assign rd_mux = sel_ctrl ? ctrl_rd :
                  sel_prog_addr ? {17'h00000, prog_addr_r} :
                  sel_prog_data ? prog_data_rd :
                  sel_status ? status_rd :
                  sel_revision ? {18'h00000, silicon_revision_word} : // R03
                  sel_part ? {18'h00000, part_identity_word} : // R01
                  sel_prot_cfg ? {18'h00000, protection_config_word} :
                  32'h00000000;

  // ----------------------------------------------------------------
  // APB answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (setup_acc) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  logic erase_busy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_busy_r <= 1'b0;
    end else begin
      erase_busy_r <= erase_busy_w;
    end
  end

  assign erase_busy = erase_busy_r;
  assign code_locked = lock_r;
  assign fetch_addr = pc_w;

endmodule : program_space_id_map

// file: bench/program_space_id_map_asserts.sv
// Checker for the identity map block: APB timing, identity words,
// code lock and program counter. Bound to every instance of the block.
`timescale 1ns/1ns
`include "program_space_params.svh"
module program_space_id_map_asserts
  import program_space_pkg::*;
#(
  parameter int MEM_WORDS = 2048,
  parameter logic [11:0] PART_CODE = 12'h5a1,
  parameter logic [5:0] MAJOR_STEP = 6'h01,
  parameter logic [5:0] MINOR_STEP = 6'h02
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [17:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic irq_pin, // Interrupt pin
  input wire logic [14:0] fetch_addr, // Program counter
  input wire logic [13:0] fetch_word, // Fetched word
  input wire logic code_locked, // Lock flag
  input wire logic erase_busy // Erase flag
);
  localparam logic [17:0] PART_A = {`IDX_PART, 2'b00};
  localparam logic [17:0] REV_A = {`IDX_REVISION, 2'b00};
  localparam logic [17:0] CFG_A = {`IDX_PROT_CFG, 2'b00};
  wire logic done = psel && penable && pready;
  wire logic cfg_wr = done && pwrite && (paddr == CFG_A);
  // Erase starts a cycle before the erase_busy output rises
  wire logic erase_req = done && pwrite && (paddr == `ADDR_CTRL) && pwdata[`CTRL_ERASE];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held two cycles");
  a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_idle_quiet: assert property (!(psel && penable) |=> !pready && !pslverr) else $error("answer without access");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_part_word: assert property (done && !pwrite && paddr == PART_A |->
    prdata == {18'h0, 2'b11, PART_CODE}) else $error("part word wrong");
  a_rev_word: assert property (done && !pwrite && paddr == REV_A |->
    prdata == {18'h0, 2'b10, MAJOR_STEP, MINOR_STEP}) else $error("revision word wrong");
  a_lock_set: assert property (cfg_wr && !pwdata[0] && !erase_busy && !$past(erase_req) |->
    ##[1:2] code_locked) else $error("lock not set");
  a_lock_kept: assert property ($fell(code_locked) |-> erase_busy || $past(erase_busy))
    else $error("lock cleared without erase");
  a_pc_range: assert property (fetch_addr < MEM_WORDS) else $error("pc beyond memory");
  a_reset_pc: assert property (!$past(presetn) |-> fetch_addr == 15'h0) else $error("pc not at zero");

  cover property (done && !pwrite && paddr == PART_A);
  cover property ($rose(code_locked));
  cover property ($fell(code_locked));
  cover property (fetch_addr == 15'h4);
endmodule : program_space_id_map_asserts

bind program_space_id_map program_space_id_map_asserts #(.MEM_WORDS(MEM_WORDS), .PART_CODE(PART_CODE),
  .MAJOR_STEP(MAJOR_STEP), .MINOR_STEP(MINOR_STEP)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_pin(irq_pin), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
  .code_locked(code_locked), .erase_busy(erase_busy));

// file: bench/test_program_space_id_map.sv
// Self-checking bench for the identity map block over APB.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
`include "program_space_params.svh"
module test_program_space_id_map
  import program_space_pkg::*;
();
  localparam int MEM_WORDS = 2048;
  localparam logic [11:0] PART_CODE = 12'h3c5; // Arbitrary value
  localparam logic [5:0] MAJOR_STEP = 6'h2a; // Arbitrary value
  localparam logic [5:0] MINOR_STEP = 6'h15; // Arbitrary value
  localparam logic [17:0] REV_A = {`IDX_REVISION, 2'b00};
  localparam logic [17:0] PART_A = {`IDX_PART, 2'b00};
  localparam logic [17:0] CFG_A = {`IDX_PROT_CFG, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic irq_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [14:0] fetch_addr;
  prog_word_type fetch_word;
  logic code_locked;
  logic erase_busy;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  logic ok;

  always #5 pclk = ~pclk;

  program_space_id_map #(.MEM_WORDS(MEM_WORDS), .PART_CODE(PART_CODE), .MAJOR_STEP(MAJOR_STEP),
    .MINOR_STEP(MINOR_STEP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin(irq_pin), .fetch_addr(fetch_addr), .fetch_word(fetch_word), .code_locked(code_locked),
    .erase_busy(erase_busy));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0t run timed out", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // ----------------------------------------
  // APB master: setup, access until pready
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1, "pready");
    chk(32'(n), 32'h2, "access cycles");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic err, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
    chk({31'h0, e}, {31'h0, err}, what);
  endtask : rd_chk

  task automatic wait_pc(input logic [14:0] v, input int lim);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge pclk);
      ok = (fetch_addr === v);
    end
  endtask : wait_pc

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({17'h0, fetch_addr}, 32'h0, "reset pc");
    chk({31'h0, code_locked}, 32'h0, "reset lock");
    $display("test reset done");
    rd_chk(PART_A, {18'h0, 2'b11, PART_CODE}, 1'b0, "part");
    rd_chk(REV_A, {18'h0, 2'b10, MAJOR_STEP, MINOR_STEP}, 1'b0, "rev");
    apb(1'b1, PART_A, 32'h0);
    apb(1'b1, REV_A, 32'hffffffff);
    rd_chk(PART_A, {18'h0, 2'b11, PART_CODE}, 1'b0, "part after write");
    rd_chk(REV_A, {18'h0, 2'b10, MAJOR_STEP, MINOR_STEP}, 1'b0, "rev after write");
    rd_chk(18'h00100, 32'h0, 1'b1, "unmapped");
    $display("test identity done");
    apb(1'b1, `ADDR_PROG_ADDR, 32'h5);
    apb(1'b1, `ADDR_PROG_DATA, 32'h1234);
    apb(1'b1, `ADDR_PROG_ADDR, 32'(MEM_WORDS + 5));
    rd_chk(`ADDR_PROG_DATA, 32'h1234, 1'b0, "wrapped data read");
    $display("test wrap done");
    apb(1'b1, `ADDR_CTRL, 32'h1);
    wait_pc(15'h5, 20);
    chk({31'h0, ok}, 32'h1, "pc reaches 5");
    @(negedge pclk);
    chk({18'h0, fetch_word}, 32'h1234, "fetched word");
    wait_pc(15'(MEM_WORDS - 1), MEM_WORDS + 10);
    chk({31'h0, ok}, 32'h1, "pc reaches last word");
    @(negedge pclk);
    chk({17'h0, fetch_addr}, 32'h0, "pc wraps");
    rd_chk(`ADDR_PROG_DATA, 32'h1234, 1'b0, "data read while fetching");
    $display("test fetch done");
    apb(1'b1, `ADDR_CTRL, 32'hb);
    wait_pc(15'h0, 4);
    chk({31'h0, ok}, 32'h1, "restart vector");
    repeat (20) @(posedge pclk);
    irq_pin <= 1'b1;
    wait_pc(15'h4, 8);
    chk({31'h0, ok}, 32'h1, "interrupt vector");
    @(posedge pclk);
    irq_pin <= 1'b0;
    $display("test vectors done");
    apb(1'b1, CFG_A, 32'h3ffe);
    rd_chk(CFG_A, 32'h3ffe, 1'b0, "lock word");
    chk({31'h0, code_locked}, 32'h1, "locked");
    apb(1'b1, CFG_A, 32'h3fff);
    rd_chk(CFG_A, 32'h3ffe, 1'b0, "lock kept after write");
    rd_chk(`ADDR_PROG_DATA, 32'h0, 1'b0, "locked data read");
    apb(1'b1, `ADDR_CTRL, 32'h4);
    repeat (3) @(negedge pclk);
    chk({31'h0, erase_busy}, 32'h1, "erasing");
    chk({31'h0, code_locked}, 32'h1, "locked while erasing");
    ok = 1'b0;
    for (int i = 0; i < MEM_WORDS + 20 && !ok; i++) begin
      @(negedge pclk);
      ok = (code_locked === 1'b0);
    end
    chk({31'h0, ok}, 32'h1, "erase clears lock");
    rd_chk(`ADDR_PROG_DATA, {18'h0, `ERASED_WORD}, 1'b0, "erased word");
    $display("test lock done");
    end_of_test();
  end
endmodule : test_program_space_id_map
